/* rtl/clocked_slave_serial_transceiver.sv */
// Purpose: Slave serial channel, shifting out and in on a master-driven clock
// Assumes: APB slave with zero wait states; link clock at most pclk/6
// Notes:   Single data word holds pending transmit byte and last received byte
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "serial_slave_defines.svh"

// Operation
// [RQ1] Slave only: shift out and in on the clock driven by the master.
// [RQ2] Interrupt source: transfer end, or buffer empty for continuous transfers.
// [RQ3] Only overrun is detected, on its own flag; no parity or framing.
// [RQ4] Link clock is sampled by pclk; master keeps it at most pclk/6.
// [RQ5] Data phase 0 starts on first clock edge; 1 starts half period earlier.
// [RQ6] Clock polarity setting uses the serial clock plain or inverted.
// [RQ7] Frames are 7 or 8 bits, MSB or LSB first.
// [RQ8] Software loads the first transmit byte before the master clocks.
// [RQ9] A data write while the buffer is full replaces the pending byte.
// [RQ10] Continuous mode read while shifting returns pending transmit data, undisturbed.
// [RQ11] Source select stays writable during operation, changed before the last bit.
// [RQ12] Software switches to transfer end for the final continuous byte.
// [RQ13] In continuous mode the first buffer-empty interrupt precedes any reception.
// [RQ14] Writing one to the stop bit halts the channel.
// [RQ15] After enable change with clock removed, software reinitialises fully.
module clocked_slave_serial_transceiver #(
  parameter int DATA_W = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               slave_serial_clock_in,
  input  wire logic               slave_serial_data_in,
  output logic                    slave_serial_data_out,
  output logic                    channel_irq
);
  import serial_slave_pkg::*;

  xfer_state_t       state;
  logic [DATA_W-1:0] tx_buf;
  logic [DATA_W-1:0] tx_shift;
  logic [DATA_W-1:0] rx_shift;
  logic [DATA_W-1:0] next_rx_shift;
  logic [DATA_W-1:0] rx_data;
  logic [3:0]        bit_cnt;
  logic              run;
  logic              started;
  logic              buffer_full_flag;
  logic              overrun_flag;
  logic              rx_full;
  logic              irq_source_sel;
  logic              data_phase_sel;
  logic              clock_polarity_sel;
  logic              len7;
  logic              lsb_first;
  logic              setup;
  logic              wr;
  logic              rd;
  logic              data_wr;
  logic              stop_wr;
  logic              load;
  logic              shift_edge;
  logic              sample_edge;
  logic              last_bit;
  logic              frame_end;
  logic [DATA_W-1:0] first_order;

  sclk_edge_if edges ();

  // Pin synchroniser and edge finder
  sclk_edge_finder u_edge (
    .pclk                  (pclk),
    .presetn               (presetn),
    .slave_serial_clock_in (slave_serial_clock_in),
    .slave_serial_data_in  (slave_serial_data_in),
    .clock_polarity_sel    (clock_polarity_sel),
    .edges                 (edges)
  );

  // Address decode for the error answer; the read mux decodes paddr by itself
  function automatic logic is_mapped(input logic [`ADDR_W-1:0] a);
    return (a == `OFS_DATA) || (a == `OFS_MODE) ||
           (a == `OFS_CTRL) || (a == `OFS_STATUS);
  endfunction : is_mapped

  // Reorders a byte so that bit 0 is the first to leave the pin
  function automatic logic [DATA_W-1:0] tx_order(
    input logic [DATA_W-1:0] d,
    input logic              lsb,
    input logic              short
  );
    logic [DATA_W-1:0] r;
    r = d;
    if (!lsb)
    begin
      for (int i = 0; i < DATA_W; i++)
      begin
        if (short)
          r[i] = (i < DATA_W - 1) ? d[DATA_W-2-i] : 1'b0;
        else
          r[i] = d[DATA_W-1-i];
      end
    end
    return r;
  endfunction : tx_order

  // APB phases; writes and read side effects land at the access edge
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign data_wr = wr && (paddr == `OFS_DATA);
  assign stop_wr = wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_STOP];
  assign pready  = 1'b1; // Read data is already registered in the setup cycle

  // Edge roles follow the data phase: phase 1 shifts on trail, samples on lead
  assign shift_edge  = data_phase_sel ? edges.trail : edges.lead;  // RQ5
  assign sample_edge = data_phase_sel ? edges.lead  : edges.trail; // RQ5
  assign last_bit    = bit_cnt == (len7 ? 4'(DATA_W - 2) : 4'(DATA_W - 1)); // RQ7
  assign frame_end   = (state == SHIFT) && sample_edge && last_bit;
  assign load        = run && (state == IDLE) && buffer_full_flag; // RQ8
  assign first_order = tx_order(tx_buf, lsb_first, len7);

  // Incoming bit enters from the end matching the bit order
  always_comb
  begin
    if (lsb_first)
      next_rx_shift = {edges.sdi, rx_shift[DATA_W-1:1]}; // RQ7
    else
      next_rx_shift = {rx_shift[DATA_W-2:0], edges.sdi};
  end

  // Mode settings; live writes allowed, including mid-transfer source change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {lsb_first, len7, clock_polarity_sel, data_phase_sel, irq_source_sel} <= `MODE_RST;
    else if (wr && (paddr == `OFS_MODE))
    begin
      irq_source_sel     <= pwdata[`MODE_SEL]; // RQ11
      data_phase_sel     <= pwdata[`MODE_DAP];
      clock_polarity_sel <= pwdata[`MODE_CKP];
      len7               <= pwdata[`MODE_LEN7];
      lsb_first          <= pwdata[`MODE_LSB];
    end
  end

  // Run state: start sets, stop wins over start in the same write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run <= 1'b0;
    else if (stop_wr)
      run <= 1'b0; // RQ14
    else if (wr && (paddr == `OFS_CTRL) && pwdata[`CTRL_START])
      run <= 1'b1;
  end

  // Transmit buffer; a write while full simply replaces the pending byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_buf <= '0;
    else if (data_wr)
      tx_buf <= pwdata[DATA_W-1:0]; // RQ9
  end

  // Buffer-full flag: a write in the load cycle stays pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      buffer_full_flag <= 1'b0;
    else if (data_wr)
      buffer_full_flag <= 1'b1;
    else if (load)
      buffer_full_flag <= 1'b0;
  end

  // Transfer sequencer; no clock leaves this block, it only follows the master
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state                 <= IDLE;
      tx_shift              <= '0;
      bit_cnt               <= 4'h0;
      started               <= 1'b0;
      slave_serial_data_out <= `IDLE_LVL;
    end
    else if (stop_wr || !run)
    begin
      state                 <= IDLE; // RQ14
      started               <= 1'b0;
      bit_cnt               <= 4'h0;
      slave_serial_data_out <= `IDLE_LVL;
    end
    else
    begin
      case (state)
        IDLE:
        begin
          if (load)
          begin
            state    <= SHIFT;
            tx_shift <= first_order;
            bit_cnt  <= 4'h0;
            started  <= data_phase_sel;
            // Phase 1 puts the first bit out before any clock edge
            if (data_phase_sel)
              slave_serial_data_out <= first_order[0]; // RQ5
          end
        end
        SHIFT:
        begin
          if (shift_edge)
          begin
            if (started)
            begin
              tx_shift              <= tx_shift >> 1;
              slave_serial_data_out <= tx_shift[1]; // RQ1
            end
            else
            begin
              started               <= 1'b1;
              slave_serial_data_out <= tx_shift[0]; // RQ5
            end
          end
          if (sample_edge)
          begin
            bit_cnt <= bit_cnt + 4'h1;
            if (last_bit)
            begin
              state   <= IDLE;
              started <= 1'b0;
            end
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  // Receive shifter; only moves while a frame is under way
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_shift <= '0;
    else if ((state == SHIFT) && sample_edge && run)
      rx_shift <= next_rx_shift; // RQ1
  end

  // Received byte, aligned to bit 0 for seven-bit frames
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_data <= '0;
    else if (frame_end && run)
    begin
      if (len7 && lsb_first)
        rx_data <= {1'b0, next_rx_shift[DATA_W-1:1]}; // RQ7
      else if (len7)
        rx_data <= {1'b0, next_rx_shift[DATA_W-2:0]};
      else
        rx_data <= next_rx_shift;
    end
  end

  // Unread-data flag; a new frame wins over a read in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_full <= 1'b0;
    else if (frame_end && run)
      rx_full <= 1'b1;
    else if (rd && (paddr == `OFS_DATA))
      rx_full <= 1'b0;
  end

  // Overrun: frame completes while the previous byte is unread; write one clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overrun_flag <= 1'b0;
    else if (frame_end && run && rx_full)
      overrun_flag <= 1'b1; // RQ3
    else if (wr && (paddr == `OFS_STATUS) && pwdata[`STAT_OVF])
      overrun_flag <= 1'b0;
  end

  // Channel interrupt pulse from the selected source
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      channel_irq <= 1'b0;
    else
      channel_irq <= (frame_end && run && !irq_source_sel) || // RQ2
                     (load && irq_source_sel);                // RQ13
  end

  // Read data captured in the setup cycle, so pready can stay high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !is_mapped(paddr);
      case (paddr)
        `OFS_DATA:
          // Pending byte is shown while shifting in continuous mode
          if (irq_source_sel && (state == SHIFT) && buffer_full_flag)
            prdata <= 32'(tx_buf); // RQ10
          else
            prdata <= 32'(rx_data);
        `OFS_MODE:
          prdata <= 32'({lsb_first, len7, clock_polarity_sel,
                         data_phase_sel, irq_source_sel});
        `OFS_CTRL:
          prdata <= 32'(run);
        `OFS_STATUS:
          prdata <= 32'({run, rx_full, overrun_flag, state == SHIFT, buffer_full_flag});
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
    stop_wr |=> (state == IDLE) && !run && slave_serial_data_out)
    else $error("stop write did not halt the channel");

  a_tx_overwrite: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (data_wr && buffer_full_flag) |=> buffer_full_flag &&
      (tx_buf == $past(pwdata[DATA_W-1:0])))
    else $error("pending transmit byte not replaced");

  a_overrun_set: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (frame_end && run && rx_full) |=> overrun_flag && rx_full)
    else $error("overrun not flagged");

  a_irq_source: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    channel_irq |-> $past(irq_source_sel) ? $past(load) : $past(frame_end))
    else $error("interrupt from unselected source");

  a_phase_early: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    (load && data_phase_sel && !stop_wr) |=>
      (slave_serial_data_out == $past(first_order[0])) && started)
    else $error("first bit not presented before clock");

  a_pending_read: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    (setup && (paddr == `OFS_DATA) && irq_source_sel && (state == SHIFT) && buffer_full_flag)
      |=> (prdata == 32'($past(tx_buf))) && ((state == $past(state)) || $past(frame_end)))
    else $error("pending transmit byte not returned");

  a_frame_length: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    (state == SHIFT) && sample_edge && run && !stop_wr && !last_bit |=>
      (state == SHIFT) && (bit_cnt == $past(bit_cnt) + 4'h1))
    else $error("frame ended at the wrong bit count");

  a_mode_live: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (wr && (paddr == `OFS_MODE)) |=> irq_source_sel == $past(pwdata[`MODE_SEL]))
    else $error("source select write lost");

  a_out_on_edge: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    $changed(slave_serial_data_out) |->
      $past(shift_edge || load || stop_wr || !run))
    else $error("data output moved without a master clock edge");

endmodule : clocked_slave_serial_transceiver

/* rtl/sclk_edge_finder.sv */
// Purpose: Synchronises the serial clock and data pins and finds clock edges
// Assumes: Link clock at most pclk/6, so each half lasts three or more cycles
// Notes:   Polarity applied after the synchroniser
`timescale 1ns/1ns
`include "serial_slave_defines.svh"
module sclk_edge_finder (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slave_serial_clock_in,
  input  wire logic       slave_serial_data_in,
  input  wire logic       clock_polarity_sel,
  sclk_edge_if.src        edges
);
  logic [2:0] ck_sync;
  logic [1:0] di_sync;
  logic       lvl;
  logic       prev;

  // Two flops before any logic; third stage only keeps history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ck_sync <= {3{`IDLE_LVL}};
      di_sync <= 2'h0;
    end
    else
    begin
      ck_sync <= {ck_sync[1:0], slave_serial_clock_in}; // RQ4
      di_sync <= {di_sync[0], slave_serial_data_in};
    end
  end

  // Inverted use of the clock when polarity is set; both stages flip together, so a change mid-frame fakes no edge
  assign lvl  = ck_sync[1] ^ clock_polarity_sel; // RQ6
  assign prev = ck_sync[2] ^ clock_polarity_sel;

  // Data sync has the same depth, so sdi lines up with the edge pulse
  assign edges.lead  = prev & ~lvl;
  assign edges.trail = ~prev & lvl;
  assign edges.sdi   = di_sync[1];

  // Checked against the raw pin, so a wrong synchroniser depth or polarity shows up
  a_trail_polarity: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    edges.trail |-> ($past(slave_serial_clock_in, 2) != clock_polarity_sel) &&
      ($past(slave_serial_clock_in, 3) == clock_polarity_sel))
    else $error("trail edge not on polarity-corrected rise");

  a_sample_spacing: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    edges.lead |=> !edges.trail [*2])
    else $error("link clock faster than pclk/6");

endmodule : sclk_edge_finder

/* rtl/sclk_edge_if.sv */
// Purpose: Carries synchronised link clock edges and data bit
// Assumes: All signals on pclk
// Notes:   lead and trail are one-cycle pulses
`timescale 1ns/1ns
interface sclk_edge_if;
  logic lead;
  logic trail;
  logic sdi;
  modport src (output lead, output trail, output sdi);
  modport dst (input lead, input trail, input sdi);
endinterface : sclk_edge_if

/* rtl/serial_slave_defines.svh */
// Purpose: Register map, field positions and reset values of the slave serial channel
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes:   Definitions only
`ifndef SERIAL_SLAVE_DEFINES_SVH
`define SERIAL_SLAVE_DEFINES_SVH

`define ADDR_W        8
// Register byte offsets
`define OFS_DATA      8'h00
`define OFS_MODE      8'h04
`define OFS_CTRL      8'h08
`define OFS_STATUS    8'h0C
// Mode register fields
`define MODE_SEL      0
`define MODE_DAP      1
`define MODE_CKP      2
`define MODE_LEN7     3
`define MODE_LSB      4
`define MODE_RST      5'h00
// Control register fields (write one to act)
`define CTRL_START    0
`define CTRL_STOP     1
// Status register fields
`define STAT_BFF      0
`define STAT_BUSY     1
`define STAT_OVF      2
`define STAT_RXF      3
`define STAT_RUN      4
// Idle level of the link clock and data output
`define IDLE_LVL      1'b1

`endif

/* rtl/serial_slave_pkg.sv */
// Purpose: Types shared by the slave serial channel
// Assumes: Constants live in serial_slave_defines.svh
// Notes:   Types only
package serial_slave_pkg;

  typedef enum logic {IDLE, SHIFT} xfer_state_t;

endpackage : serial_slave_pkg

/* tb/spi_master_model.sv */
// Purpose: Master at the far side of the link, clocking one frame per call
// Assumes: Link clock period 160 ns; clock stands still between frames
// Notes:   Data line shows the inverse of its last bit once released
`timescale 1ns/1ns
module spi_master_model (
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso
);
  localparam int HALF = 80; // Half period of 8 pclk, above the three-cycle floor

  // Idle levels at time zero
  initial
  begin
    sclk = 1'b1;
    mosi = 1'b0;
  end

  // Park the clock at its idle level before the channel starts, so no edge is faked
  task automatic set_idle(input logic ckp);
    sclk <= ~ckp;
  endtask : set_idle

  // One frame: data phase picks the edge that drives and the edge that samples
  task automatic xfer(input logic [7:0] tx, input logic len7, input logic lsb,
                      input logic dap, input logic ckp, output logic [7:0] rx);
    int n;
    int b;
    n = len7 ? 7 : 8;
    rx = 8'h00;
    // Pins move by non-blocking assignment on pclk edges, so no sampling race
    sclk <= ~ckp;
    if (dap)
      mosi <= tx[lsb ? 0 : n - 1]; // First bit half a period early
    for (int i = 0; i < n; i++)
    begin
      b = lsb ? i : n - 1 - i;
      #HALF;
      sclk <= ckp; // Lead edge
      if (dap)
        rx[b] = miso;
      else
        mosi <= tx[b];
      #HALF;
      sclk <= ~ckp; // Trail edge
      if (!dap)
        rx[b] = miso;
      else if (i < n - 1)
        mosi <= tx[lsb ? i + 1 : n - 2 - i];
    end
    #HALF;
    mosi <= ~mosi; // Released: do not leave the last value looking valid
  endtask : xfer
endmodule : spi_master_model

/* tb/test_clocked_slave_serial_transceiver.sv */
// Purpose: Self-checking bench for the slave serial channel
// Assumes: Zero-wait APB slave; master model clocks frames at 160 ns
// Notes:   Plain frames run from a table, awkward cases follow by hand
`timescale 1ns/1ns
`include "serial_slave_defines.svh"
module test_clocked_slave_serial_transceiver;
  typedef struct packed {logic [4:0] mode; logic [7:0] dtx; logic [7:0] mtx;} row_t;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        channel_irq;
  logic [31:0] irq_count;
  logic [31:0] base;
  logic [31:0] rd;
  logic [7:0]  rx;
  logic [7:0]  rx2;
  int          n_errors;
  int          samples_checked;
  // Mode bits: b0 source, b1 data phase, b2 polarity, b3 seven bits, b4 LSB first
  row_t        rows [0:6] = '{'{5'h00, 8'hA5, 8'h3C}, '{5'h02, 8'h96, 8'h1E},
                              '{5'h04, 8'h81, 8'hF0}, '{5'h06, 8'h4B, 8'hD2},
                              '{5'h08, 8'hE7, 8'h55}, '{5'h10, 8'h0D, 8'hB4},
                              '{5'h1E, 8'h6C, 8'h39}};

  clocked_slave_serial_transceiver uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slave_serial_clock_in(sclk),
    .slave_serial_data_in(mosi), .slave_serial_data_out(miso), .channel_irq(channel_irq));

  spi_master_model master (.sclk(sclk), .mosi(mosi), .miso(miso));

  // 100 MHz clock
  initial
    pclk = 1'b0;
  always #5 pclk = ~pclk;

  // Interrupts are one-cycle pulses, so counting them catches doubles and misses
  always @(posedge pclk)
    if (channel_irq === 1'b1)
      irq_count <= irq_count + 32'h0000_0001;

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    check_bit("pready", 1'b1, pready);
    d = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
  endtask : wr

  task automatic rdw(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0000_0000, d, e);
  endtask : rdw

  // Polarity may only change while stopped, so stop first
  task automatic setup(input logic [4:0] mode);
    wr(`OFS_CTRL, 32'h0000_0002);
    wr(`OFS_MODE, {27'h000_0000, mode});
    master.set_idle(mode[`MODE_CKP]);
  endtask : setup

  task automatic frame(input logic [4:0] mode, input logic [7:0] mtx, output logic [7:0] mrx);
    master.xfer(mtx, mode[`MODE_LEN7], mode[`MODE_LSB], mode[`MODE_DAP], mode[`MODE_CKP], mrx);
    repeat (10) @(posedge pclk);
  endtask : frame

  task automatic test_end(input string what);
    $display("test %s done", what);
  endtask : test_end

  // Generous bound: 200 us, far above thirteen frames of 1.3 us plus register traffic
  initial
  begin
    #200000;
    n_errors++;
    $display("BAD watchdog expected finish seen hang");
    results();
  end

  initial
  begin
    logic [7:0] m;
    logic       e;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    irq_count = 32'h0000_0000;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    check_bit("data out in reset", `IDLE_LVL, miso);
    check_bit("irq in reset", 1'b0, channel_irq);
    presetn <= 1'b1;
    rdw(`OFS_MODE, rd);
    check_word("mode reset", 32'h0000_0000, rd);
    rdw(`OFS_CTRL, rd);
    check_word("ctrl reset", 32'h0000_0000, rd);
    rdw(`OFS_STATUS, rd);
    check_word("status reset", 32'h0000_0000, rd);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, e);
    check_bit("unmapped error", 1'b1, e);
    check_word("unmapped read", 32'h0000_0000, rd);
    test_end("reset");
    // Table: every phase, polarity, length and order setting
    foreach (rows[i])
    begin
      m = rows[i].mode[`MODE_LEN7] ? 8'h7F : 8'hFF;
      setup(rows[i].mode);
      base = irq_count;
      wr(`OFS_DATA, {24'h00_0000, rows[i].dtx});
      wr(`OFS_CTRL, 32'h0000_0001);
      repeat (4) @(posedge pclk);
      frame(rows[i].mode, rows[i].mtx, rx);
      check_word("master rx", {24'h00_0000, rows[i].dtx & m}, {24'h00_0000, rx});
      rdw(`OFS_DATA, rd);
      check_word("device rx", {24'h00_0000, rows[i].mtx & m}, rd);
      check_word("end irq", base + 32'h0000_0001, irq_count);
    end
    test_end("table");
    // Overwrite while full, then a second frame with nothing read
    setup(5'h00);
    wr(`OFS_DATA, 32'h0000_0011);
    rdw(`OFS_STATUS, rd);
    check_word("status full", 32'h0000_0001, rd);
    wr(`OFS_DATA, 32'h0000_00C3);
    wr(`OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    frame(5'h00, 8'h5A, rx);
    check_word("replaced tx", 32'h0000_00C3, {24'h00_0000, rx});
    wr(`OFS_DATA, 32'h0000_003C);
    repeat (4) @(posedge pclk);
    frame(5'h00, 8'h69, rx);
    rdw(`OFS_STATUS, rd);
    check_bit("overrun set", 1'b1, rd[`STAT_OVF]);
    wr(`OFS_STATUS, 32'h0000_0004);
    rdw(`OFS_STATUS, rd);
    check_bit("overrun clear", 1'b0, rd[`STAT_OVF]);
    rdw(`OFS_DATA, rd);
    check_word("latest rx", 32'h0000_0069, rd);
    test_end("overrun");
    // Continuous: empty irq at load, pending read mid-frame, switch before last byte
    setup(5'h01);
    base = irq_count;
    wr(`OFS_DATA, 32'h0000_00A1);
    wr(`OFS_CTRL, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    check_word("first empty irq", base + 32'h0000_0001, irq_count);
    wr(`OFS_DATA, 32'h0000_00B2);
    fork
      frame(5'h01, 8'h17, rx);
      begin
        repeat (40) @(posedge pclk);
        rdw(`OFS_DATA, rd);
        check_word("pending tx read", 32'h0000_00B2, rd);
      end
    join
    check_word("first byte", 32'h0000_00A1, {24'h00_0000, rx});
    check_word("second empty irq", base + 32'h0000_0002, irq_count);
    wr(`OFS_MODE, 32'h0000_0000);
    frame(5'h00, 8'h28, rx2);
    check_word("last byte", 32'h0000_00B2, {24'h00_0000, rx2});
    check_word("final end irq", base + 32'h0000_0003, irq_count);
    rdw(`OFS_DATA, rd);
    check_word("last rx", 32'h0000_0028, rd);
    wr(`OFS_STATUS, 32'h0000_0004);
    test_end("continuous");
    // Stop in mid-frame: output idles, no completion follows
    setup(5'h00);
    wr(`OFS_DATA, 32'h0000_0000);
    wr(`OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    base = irq_count;
    fork
      frame(5'h00, 8'hFF, rx);
      begin
        repeat (50) @(posedge pclk);
        wr(`OFS_CTRL, 32'h0000_0002);
        repeat (5) @(posedge pclk);
        check_bit("idle after stop", `IDLE_LVL, miso);
        rdw(`OFS_CTRL, rd);
        check_word("ctrl stopped", 32'h0000_0000, rd);
      end
    join
    check_word("no irq after stop", base, irq_count);
    test_end("stop");
    // Master has finished the cut frame; reinitialise fully, stop beats start
    setup(5'h00);
    wr(`OFS_CTRL, 32'h0000_0003);
    rdw(`OFS_CTRL, rd);
    check_word("stop wins", 32'h0000_0000, rd);
    wr(`OFS_DATA, 32'h0000_005C);
    wr(`OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    frame(5'h00, 8'hC6, rx);
    check_word("reinit tx", 32'h0000_005C, {24'h00_0000, rx});
    rdw(`OFS_DATA, rd);
    check_word("reinit rx", 32'h0000_00C6, rd);
    test_end("reinit");
    results();
  end
endmodule : test_clocked_slave_serial_transceiver
